/* File: brl_readout.v */
// bridge and load-cell readout: conversion sequencing, gain choice, clamp and load
`timescale 1ns/1ps
`default_nettype none
`include "brl_defines.vh"

// Contract
// - bridge gain is largest power of two, up to 128, strictly below ref over max input
// - max input is rated output times excitation times overrange percent over 100
// - clamp disabled: input limited to plus or minus reference over gain
// - clamp enabled: input limited to overrange percent times rated output times excitation
// - counts are offset binary: input times gain times 32768 over reference plus 32767
// - first convert the ratiometric reference against fixed 1.8 V at gain one
// - excitation equals recovered reference times 73.2 over 10
// - second conversion measures bridge output against the ratiometric reference
// - full-load output from excitation and rated output, extended by overrange allowance
// - bridge voltage is count minus 32767 over gain times 32768, times reference
// - once captured, the null offset is subtracted from every later measurement until a null clear
// - load is 100 percent times output over rated output times excitation, times software gain
// - converter is 24-bit bipolar; resolution depends on gain and filter
module brl_readout
(
    // clock and reset
    input  wire        clk,
    input  wire        rst_n,
    // register port
    input  wire [7:0]  reg_addr,
    input  wire [31:0] reg_wdata,
    input  wire        reg_wr,
    input  wire        reg_rd,
    output reg  [31:0] reg_rdata,
    // converter
    output reg         adc_start,
    output reg         adc_sel_bridge,
    output reg  [2:0]  adc_gain_code,
    input  wire        adc_done,
    input  wire [23:0] adc_data,
    // results
    output reg         busy,
    output reg  [31:0] load_out
);

    localparam [3:0] S_IDLE      = 4'd0;
    localparam [3:0] S_REF_WAIT  = 4'd1;
    localparam [3:0] S_EXC_WAIT  = 4'd2;
    localparam [3:0] S_GAIN      = 4'd3;
    localparam [3:0] S_LIM_WAIT  = 4'd4;
    localparam [3:0] S_BR_WAIT   = 4'd5;
    localparam [3:0] S_LOAD_WAIT = 4'd6;

    // largest gain with gain times max input strictly below the reference
    function [2:0] gain_select;
        input [47:0] vmax_x100;
        input [47:0] ref_x100;
        integer k;
        begin
            gain_select = 3'd0;
            for (k = 0; k < 8; k = k + 1)
                if ((vmax_x100 << k) < ref_x100)
                    gain_select = k[2:0];
        end
    endfunction

    // configuration
    reg         run_reg;
    reg         clamp_en_reg;
    reg  [15:0] rated_reg;
    reg  [7:0]  ovr_reg;
    reg  [15:0] swgain_reg;
    reg         null_req_reg;
    // sequencing and results
    reg  [3:0]  state_reg;
    reg  [23:0] ref_uv_reg;
    reg  [15:0] exc_mv_reg;
    reg  [38:0] ovr_lim_reg;
    reg  signed [39:0] bridge_nv_reg;
    reg  signed [39:0] null_nv_reg;
    reg         null_valid_reg;
    reg         clamped_reg;
    reg         load_neg_reg;
    reg  [38:0] limit_reg;
    // divider handshake
    reg         div_start_reg;
    reg  [47:0] div_a_reg;
    reg  [31:0] div_b_reg;
    wire        div_done;
    wire [47:0] div_q;

    brl_divider u_div
    (
        .clk      (clk),
        .rst_n    (rst_n),
        .start    (div_start_reg),
        .dividend (div_a_reg),
        .divisor  (div_b_reg),
        .done     (div_done),
        .quotient (div_q)
    );

    // offset-binary count from the top of the 24-bit word
    wire        [15:0] adc_count  = adc_data[23:8];
    wire signed [17:0] count_diff = $signed({2'b00, adc_count}) - $signed(`BRL_MID_COUNT);

    // reference recovered against the fixed reference
    wire signed [39:0] ref_prod = count_diff * $signed(`BRL_FIXED_REF_UV);
    wire signed [39:0] ref_calc = ref_prod >>> `BRL_FULL_SHIFT;
    wire        [23:0] ref_uv   = ref_calc[39] ? 24'h0 : ref_calc[23:0];

    // full-load output in nV and the comparison terms of the gain choice
    wire [31:0] fs_nv     = rated_reg * exc_mv_reg;
    wire [47:0] vmax_x100 = fs_nv * ovr_reg;
    wire [47:0] ref_x100  = ref_uv_reg * `BRL_REF_SCALE;

    // bridge output scaled by reference, gain and full count
    wire        [33:0] ref_nv  = ref_uv_reg * `BRL_NV_PER_UV;
    wire signed [52:0] vo_prod = count_diff * $signed({1'b0, ref_nv});
    wire signed [52:0] vo_shft = vo_prod >>> (`BRL_FULL_SHIFT + adc_gain_code);
    wire signed [39:0] vo_raw  = vo_shft[39:0];

    // accepted range
    wire        [33:0] lim_gain = ref_nv >> adc_gain_code;
    wire        [38:0] lim_sel  = clamp_en_reg ? ovr_lim_reg : {5'h0, lim_gain};
    wire signed [39:0] lim_pos  = $signed({1'b0, lim_sel});
    wire signed [39:0] lim_neg  = -lim_pos;
    wire               over_hi  = vo_raw > lim_pos;
    wire               over_lo  = vo_raw < lim_neg;
    wire signed [39:0] vo_cl    = over_hi ? lim_pos : (over_lo ? lim_neg : vo_raw);

    // offset removal and magnitude for the load division
    wire signed [39:0] null_use = null_req_reg ? vo_cl : (null_valid_reg ? null_nv_reg : 40'sh0);
    wire signed [40:0] net_nv   = {vo_cl[39], vo_cl} - {null_use[39], null_use};
    wire        [40:0] net_mag  = net_nv[40] ? (~net_nv + 41'h1) : net_nv;
    wire        [47:0] load_num = net_mag[33:0] * `BRL_LOAD_SCALE;

    // load in hundredths of a percent, scaled by the software gain
    wire [47:0] load_sc  = div_q[31:0] * swgain_reg;
    wire [31:0] load_mag = load_sc[`BRL_SWGAIN_FRAC +: 32];

    // register access, one cycle read latency
    always @(posedge clk)
    begin
        if (!rst_n)
            reg_rdata <= 32'h0;
        else if (reg_rd)
        begin
            if (reg_addr == `BRL_OFS_CTRL)
                reg_rdata <= {30'h0, clamp_en_reg, run_reg};
            else if (reg_addr == `BRL_OFS_RATED)
                reg_rdata <= {16'h0, rated_reg};
            else if (reg_addr == `BRL_OFS_OVR)
                reg_rdata <= {24'h0, ovr_reg};
            else if (reg_addr == `BRL_OFS_SWGAIN)
                reg_rdata <= {16'h0, swgain_reg};
            else if (reg_addr == `BRL_OFS_STATUS)
                reg_rdata <= {25'h0, null_valid_reg, clamped_reg, busy, 1'b0, adc_gain_code};
            else if (reg_addr == `BRL_OFS_EXC)
                reg_rdata <= {16'h0, exc_mv_reg};
            else if (reg_addr == `BRL_OFS_REF)
                reg_rdata <= {8'h0, ref_uv_reg};
            else if (reg_addr == `BRL_OFS_BRIDGE)
                reg_rdata <= bridge_nv_reg[31:0];
            else if (reg_addr == `BRL_OFS_LOAD)
                reg_rdata <= load_out;
            else if (reg_addr == `BRL_OFS_NULL)
                reg_rdata <= null_nv_reg[31:0];
            else if (reg_addr == `BRL_OFS_LIMIT)
                reg_rdata <= limit_reg[31:0];
            else
                reg_rdata <= 32'h0;
        end
        else
            reg_rdata <= 32'h0;
    end

    // configuration writes and the measurement sequence
    always @(posedge clk)
    begin
        if (!rst_n)
        begin
            run_reg        <= 1'b0;
            clamp_en_reg   <= 1'b0;
            rated_reg      <= `BRL_RST_RATED;
            ovr_reg        <= `BRL_RST_OVR;
            swgain_reg     <= `BRL_RST_SWGAIN;
            null_req_reg   <= 1'b0;
            state_reg      <= S_IDLE;
            ref_uv_reg     <= 24'h0;
            exc_mv_reg     <= 16'h0;
            ovr_lim_reg    <= 39'h0;
            bridge_nv_reg  <= 40'sh0;
            null_nv_reg    <= 40'sh0;
            null_valid_reg <= 1'b0;
            clamped_reg    <= 1'b0;
            load_neg_reg   <= 1'b0;
            limit_reg      <= 39'h0;
            div_start_reg  <= 1'b0;
            div_a_reg      <= 48'h0;
            div_b_reg      <= 32'h0;
            adc_start      <= 1'b0;
            adc_sel_bridge <= 1'b0;
            adc_gain_code  <= 3'h0;
            busy           <= 1'b0;
            load_out       <= 32'h0;
        end
        else
        begin
            adc_start     <= 1'b0;
            div_start_reg <= 1'b0;
            busy          <= (state_reg != S_IDLE);

            if (reg_wr && reg_addr == `BRL_OFS_CTRL)
            begin
                run_reg      <= reg_wdata[`BRL_CTRL_RUN];
                clamp_en_reg <= reg_wdata[`BRL_CTRL_CLAMP];
                if (reg_wdata[`BRL_CTRL_NULL_CLR])
                    null_valid_reg <= 1'b0;
            end
            if (reg_wr && reg_addr == `BRL_OFS_RATED)
                rated_reg <= reg_wdata[15:0];
            if (reg_wr && reg_addr == `BRL_OFS_OVR)
                ovr_reg <= reg_wdata[7:0];
            if (reg_wr && reg_addr == `BRL_OFS_SWGAIN)
                swgain_reg <= reg_wdata[15:0];

            // capture request stays pending until a bridge result takes it
            if (reg_wr && reg_addr == `BRL_OFS_CTRL && reg_wdata[`BRL_CTRL_NULL_CAP])
                null_req_reg <= 1'b1;
            else if (state_reg == S_BR_WAIT && adc_done && null_req_reg)
                null_req_reg <= 1'b0;

            case (state_reg)
                S_IDLE:
                begin
                    if (run_reg)
                    begin
                        adc_start      <= 1'b1;
                        adc_sel_bridge <= 1'b0;
                        adc_gain_code  <= 3'h0;
                        state_reg      <= S_REF_WAIT;
                    end
                end
                S_REF_WAIT:
                begin
                    if (adc_done)
                    begin
                        ref_uv_reg    <= ref_uv;
                        div_a_reg     <= ref_uv * `BRL_DIV_NUM;
                        div_b_reg     <= `BRL_DIV_DEN_MV;
                        div_start_reg <= 1'b1;
                        state_reg     <= S_EXC_WAIT;
                    end
                end
                S_EXC_WAIT:
                begin
                    if (div_done)
                    begin
                        exc_mv_reg <= div_q[15:0];
                        state_reg  <= S_GAIN;
                    end
                end
                S_GAIN:
                begin
                    // redone on every pass, so range settings take effect at the next pass
                    adc_gain_code <= gain_select(vmax_x100, ref_x100);
                    div_a_reg     <= vmax_x100;
                    div_b_reg     <= `BRL_PCT_DEN;
                    div_start_reg <= 1'b1;
                    state_reg     <= S_LIM_WAIT;
                end
                S_LIM_WAIT:
                begin
                    if (div_done)
                    begin
                        ovr_lim_reg    <= div_q[38:0];
                        adc_start      <= 1'b1;
                        adc_sel_bridge <= 1'b1;
                        state_reg      <= S_BR_WAIT;
                    end
                end
                S_BR_WAIT:
                begin
                    if (adc_done)
                    begin
                        bridge_nv_reg <= net_nv[39:0];
                        clamped_reg   <= over_hi | over_lo;
                        limit_reg     <= lim_sel;
                        load_neg_reg  <= net_nv[40];
                        if (null_req_reg)
                        begin
                            null_nv_reg    <= vo_cl;
                            null_valid_reg <= 1'b1;
                        end
                        div_a_reg     <= load_num;
                        div_b_reg     <= fs_nv;
                        div_start_reg <= 1'b1;
                        state_reg     <= S_LOAD_WAIT;
                    end
                end
                S_LOAD_WAIT:
                begin
                    if (div_done)
                    begin
                        load_out  <= load_neg_reg ? (~load_mag + 32'h1) : load_mag;
                        state_reg <= S_IDLE;
                    end
                end
                default:
                    state_reg <= S_IDLE;
            endcase
        end
    end

endmodule // brl_readout

`default_nettype wire

/* File: brl_defines.vh */
// constants for the bridge and load-cell ratiometric readout
`ifndef BRL_DEFINES_VH
`define BRL_DEFINES_VH

// register byte offsets
`define BRL_OFS_CTRL        8'h00
`define BRL_OFS_RATED       8'h04
`define BRL_OFS_OVR         8'h08
`define BRL_OFS_SWGAIN      8'h0c
`define BRL_OFS_STATUS      8'h10
`define BRL_OFS_EXC         8'h14
`define BRL_OFS_REF         8'h18
`define BRL_OFS_BRIDGE      8'h1c
`define BRL_OFS_LOAD        8'h20
`define BRL_OFS_NULL        8'h24
`define BRL_OFS_LIMIT       8'h28

// control register fields
`define BRL_CTRL_RUN        0
`define BRL_CTRL_CLAMP      1
`define BRL_CTRL_NULL_CAP   2
`define BRL_CTRL_NULL_CLR   3

// status register fields
`define BRL_ST_GAIN_LSB     0
`define BRL_ST_BUSY         4
`define BRL_ST_CLAMPED      5
`define BRL_ST_NULL_VALID   6

// reset values
`define BRL_RST_RATED       16'h07d0
`define BRL_RST_OVR         8'h96
`define BRL_RST_SWGAIN      16'h0100

// arithmetic constants
`define BRL_MID_COUNT       18'h07fff
`define BRL_FULL_SHIFT      15
`define BRL_FIXED_REF_UV    22'h1b7740
`define BRL_DIV_NUM         10'h2dc
`define BRL_DIV_DEN_MV      32'h000186a0
`define BRL_PCT_DEN         32'h00000064
`define BRL_NV_PER_UV       34'h0000003e8
`define BRL_REF_SCALE       48'h0000000186a0
`define BRL_LOAD_SCALE      14'h2710
`define BRL_SWGAIN_FRAC     8

`endif

/* File: brl_divider.v */
// unsigned restoring divider, one quotient bit per clock
`timescale 1ns/1ps
`default_nettype none

module brl_divider
(
    // clock and reset
    input  wire        clk,
    input  wire        rst_n,
    // request
    input  wire        start,
    input  wire [47:0] dividend,
    input  wire [31:0] divisor,
    // answer
    output reg         done,
    output reg  [47:0] quotient
);

    reg  [31:0] rem_reg;
    reg  [31:0] den_reg;
    reg  [5:0]  cnt_reg;
    reg         busy_reg;
    wire [32:0] trial = {rem_reg, quotient[47]} - {1'b0, den_reg};

    always @(posedge clk)
    begin
        if (!rst_n)
        begin
            rem_reg  <= 32'h0;
            den_reg  <= 32'h0;
            cnt_reg  <= 6'h0;
            busy_reg <= 1'b0;
            done     <= 1'b0;
            quotient <= 48'h0;
        end
        else
        begin
            done <= 1'b0;
            if (start)
            begin
                rem_reg  <= 32'h0;
                den_reg  <= divisor;
                quotient <= dividend;
                cnt_reg  <= 6'h30;
                busy_reg <= 1'b1;
            end
            else if (busy_reg)
            begin
                // division by zero yields all ones for a dividend that fits in 32 bits
                if (!trial[32])
                begin
                    rem_reg  <= trial[31:0];
                    quotient <= {quotient[46:0], 1'b1};
                end
                else
                begin
                    rem_reg  <= {rem_reg[30:0], quotient[47]};
                    quotient <= {quotient[46:0], 1'b0};
                end
                cnt_reg <= cnt_reg - 6'h1;
                if (cnt_reg == 6'h1)
                begin
                    busy_reg <= 1'b0;
                    done     <= 1'b1;
                end
            end
        end
    end

endmodule // brl_divider

`default_nettype wire

/* File: brl_adc_model.sv */
// behavioural converter model answering the readout's conversion requests
`timescale 1ns/1ps
`default_nettype none

module brl_adc_model
(
    // clock and reset
    input  wire logic        clk,
    input  wire logic        rst_n,
    // conversion request
    input  wire logic        adc_start,
    input  wire logic        adc_sel_bridge,
    // conversion answer
    output var  logic        adc_done,
    output var  logic [23:0] adc_data,
    // analog scene as counts, and answer delay
    input  wire logic [15:0] ref_count,
    input  wire logic [15:0] bridge_count,
    input  wire logic [7:0]  latency
);
    logic        pend_reg;
    logic [7:0]  cnt_reg;
    logic [15:0] val_reg;

    always @(posedge clk)
    begin
        if (!rst_n)
        begin
            pend_reg <= 1'b0;
            cnt_reg  <= 8'h00;
            val_reg  <= 16'h0000;
            adc_done <= 1'b0;
            adc_data <= 24'h000000;
        end
        else
        begin
            adc_done <= 1'b0;
            // data only valid with done; toggles otherwise
            adc_data <= ~adc_data;
            if (adc_start)
            begin
                pend_reg <= 1'b1;
                cnt_reg  <= latency;
                val_reg  <= adc_sel_bridge ? bridge_count : ref_count;
            end
            else if (pend_reg)
            begin
                if (cnt_reg == 8'h00)
                begin
                    pend_reg <= 1'b0;
                    adc_done <= 1'b1;
                    adc_data <= {val_reg, 8'h5a};
                end
                else
                    cnt_reg <= cnt_reg - 8'h01;
            end
        end
    end
endmodule // brl_adc_model

`default_nettype wire

/* File: brl_readout_assertions.sv */
// port-level checker for the readout, bound to its top module
`timescale 1ns/1ps
`default_nettype none
`include "brl_defines.vh"

module brl_readout_checker
(
    // clock and reset
    input  wire logic        clk,
    input  wire logic        rst_n,
    // register port
    input  wire logic [7:0]  reg_addr,
    input  wire logic        reg_rd,
    input  wire logic [31:0] reg_rdata,
    // converter and results
    input  wire logic        adc_start,
    input  wire logic        adc_sel_bridge,
    input  wire logic [2:0]  adc_gain_code,
    input  wire logic        adc_done,
    input  wire logic        busy,
    input  wire logic [31:0] load_out
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    logic       wait_reg;
    logic       sel_reg;
    logic       last_bridge_reg;
    logic [7:0] since_reg;

    // track the conversion in flight and time since the last bridge result
    always @(posedge clk)
    begin
        if (!rst_n)
        begin
            wait_reg        <= 1'b0;
            sel_reg         <= 1'b0;
            last_bridge_reg <= 1'b1;
            since_reg       <= 8'hff;
        end
        else
        begin
            if (adc_start)
            begin
                wait_reg        <= 1'b1;
                sel_reg         <= adc_sel_bridge;
                last_bridge_reg <= adc_sel_bridge;
            end
            else if (adc_done)
                wait_reg <= 1'b0;
            if (adc_done && wait_reg && sel_reg)
                since_reg <= 8'h00;
            else if (since_reg != 8'hff)
                since_reg <= since_reg + 8'h01;
        end
    end

    rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
        else $error("read data not zero outside read answer");
    start_pulse_a: assert property (adc_start |=> !adc_start)
        else $error("conversion start longer than one cycle");
    ref_gain_a: assert property (adc_start && !adc_sel_bridge |-> adc_gain_code == 3'h0)
        else $error("reference conversion not at unity gain");
    conv_hold_a: assert property (wait_reg && !adc_start |-> $stable(adc_sel_bridge) && $stable(adc_gain_code))
        else $error("select or gain moved during conversion");
    bridge_order_a: assert property (adc_start && adc_sel_bridge |-> !last_bridge_reg)
        else $error("bridge conversion not preceded by reference conversion");
    ref_to_bridge_a: assert property (adc_done && wait_reg && !sel_reg |-> ##[1:400] (adc_start && adc_sel_bridge))
        else $error("no bridge conversion after reference result");
    next_pass_a: assert property (adc_done && wait_reg && sel_reg |-> ##[1:400] (adc_start && !adc_sel_bridge))
        else $error("no new pass after bridge result");
    load_cause_a: assert property (!$stable(load_out) |-> since_reg != 8'hff)
        else $error("load changed without a bridge result");
    load_read_a: assert property (reg_rd && reg_addr == `BRL_OFS_LOAD |=> reg_rdata == $past(load_out))
        else $error("load register differs from load output");
    busy_start_a: assert property (adc_start |-> ##[0:1] busy)
        else $error("busy low while converting");

    cover property (adc_start && adc_sel_bridge && adc_gain_code == 3'h6);
    cover property (adc_start && adc_sel_bridge && adc_gain_code == 3'h5);
    cover property (!$stable(load_out));
endmodule // brl_readout_checker

bind brl_readout brl_readout_checker chk_u (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .adc_start(adc_start), .adc_sel_bridge(adc_sel_bridge), .adc_gain_code(adc_gain_code),
    .adc_done(adc_done), .busy(busy), .load_out(load_out));

`default_nettype wire

/* File: tb_brl_readout.sv */
// self-checking testbench for the readout with a converter model
`timescale 1ns/1ps
`default_nettype none
`include "brl_defines.vh"

module tb_brl_readout;
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic [7:0]  reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic [15:0] ref_count = 16'he1ff;
    logic [15:0] bridge_count = 16'h8a66;
    logic [7:0]  latency = 8'h03;
    wire  [31:0] reg_rdata, load_out;
    wire         adc_start, adc_sel_bridge, adc_done, busy;
    wire  [2:0]  adc_gain_code;
    wire  [23:0] adc_data;
    int          failures = 0;
    int          n_tests = 0;
    longint      cfg_rated = 2000, cfg_ovr = 150, cfg_clamp = 0, cfg_sw = 256, nul;
    logic [2:0]  seen_gain = 3'h0, st_gain = 3'h0;
    logic [31:0] d;
    logic [7:0]  rst_addr [6] = '{`BRL_OFS_CTRL, `BRL_OFS_RATED, `BRL_OFS_OVR, `BRL_OFS_SWGAIN, `BRL_OFS_STATUS, 8'h2c};
    logic [31:0] rst_val [6] = '{32'h0, 32'h7d0, 32'h96, 32'h100, 32'h0, 32'h0};

    always #25 clk = ~clk;

    brl_readout dut_u (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .adc_start(adc_start), .adc_sel_bridge(adc_sel_bridge),
        .adc_gain_code(adc_gain_code), .adc_done(adc_done), .adc_data(adc_data), .busy(busy), .load_out(load_out));
    brl_adc_model adc_u (.clk(clk), .rst_n(rst_n), .adc_start(adc_start), .adc_sel_bridge(adc_sel_bridge),
        .adc_done(adc_done), .adc_data(adc_data), .ref_count(ref_count), .bridge_count(bridge_count),
        .latency(latency));

    task test_done;
        $display("comparisons %0d failures %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    task chk(input logic [31:0] got, input longint exp, input longint tol);
        longint diff;
        n_tests++;
        diff = longint'($signed(got)) - exp;
        if ((^got === 1'bx) || diff > tol || diff < -tol)
        begin
            failures++;
            $display("mismatch at %0t: got %0d expected %0d", $time, $signed(got), exp);
        end
    endtask

    task wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask

    task rd(input logic [7:0] a, output logic [31:0] v);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 v = reg_rdata;
    endtask

    task set_cfg(input logic [31:0] ctl);
        cfg_clamp = ctl[1];
        wr(`BRL_OFS_RATED, cfg_rated[31:0]);
        wr(`BRL_OFS_OVR, cfg_ovr[31:0]);
        wr(`BRL_OFS_SWGAIN, cfg_sw[31:0]);
        wr(`BRL_OFS_CTRL, ctl);
    endtask

    // count pass starts; the bridge gain is noted on the way
    task wait_refs(input int n);
        int k;
        k = 0;
        for (int t = 0; t < 20000 && k < n; t++)
        begin
            @(posedge clk);
            #1;
            if (adc_start === 1'b1 && adc_sel_bridge === 1'b1)
            begin
                seen_gain = adc_gain_code;
                // status shows the chosen code only from the gain choice until the next pass starts
                rd(`BRL_OFS_STATUS, d);
                st_gain = d[2:0];
            end
            if (adc_start === 1'b1 && adc_sel_bridge === 1'b0)
                k++;
        end
        chk(k, n, 0);
    endtask

    function longint f_r();
        return ref_count > 16'h7fff ? (longint'(ref_count) - 32767) * 1800000 / 32768 : 0;
    endfunction
    function longint f_e();
        return f_r() * 732 / 100000;
    endfunction
    function longint f_k();
        for (int k = 7; k > 0; k--)
            if ((longint'(1) << k) * cfg_rated * f_e() * cfg_ovr < f_r() * 100000)
                return k;
        return 0;
    endfunction
    function longint f_lim();
        return cfg_clamp ? cfg_rated * f_e() * cfg_ovr / 100 : (f_r() * 1000) >> f_k();
    endfunction
    function longint f_v(input longint c);
        longint v;
        v = (c - 32767) * f_r() * 1000 / (longint'(32768) << f_k());
        return v > f_lim() ? f_lim() : (v < -f_lim() ? -f_lim() : v);
    endfunction

    task check_all(input longint nv);
        longint raw, net, ld;
        raw = (longint'(bridge_count) - 32767) * f_r() * 1000 / (longint'(32768) << f_k());
        net = f_v(bridge_count) - nul;
        ld = (net < 0 ? -net : net) * 10000 / (cfg_rated * f_e()) * cfg_sw / 256;
        ld = net < 0 ? -ld : ld;
        rd(`BRL_OFS_STATUS, d);
        chk(st_gain, f_k(), 0);
        chk(seen_gain, f_k(), 0);
        chk(d[5], (raw > f_lim() || raw < -f_lim()), 0);
        chk(d[6], nv, 0);
        rd(`BRL_OFS_REF, d);
        chk(d, f_r(), 0);
        rd(`BRL_OFS_EXC, d);
        chk(d, f_e(), 0);
        rd(`BRL_OFS_LIMIT, d);
        chk(d, f_lim(), 0);
        rd(`BRL_OFS_BRIDGE, d);
        chk(d, net, 2);
        rd(`BRL_OFS_LOAD, d);
        chk(d, ld, 2);
        chk(load_out, ld, 2);
    endtask

    // one pass at the current scene and settings, then compare
    task pass(input logic [31:0] ctl, input longint nv);
        set_cfg(ctl);
        wait_refs(2);
        check_all(nv);
    endtask

    initial
    begin
        nul = 0;
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        wr(`BRL_OFS_STATUS, 32'hffffffff);
        wr(8'h2c, 32'hffffffff);
        for (int i = 0; i < 6; i++)
        begin
            rd(rst_addr[i], d);
            chk(d, rst_val[i], 0);
        end
        pass(32'h1, 0);
        latency = 8'h28;
        cfg_ovr = 100;
        pass(32'h1, 0);
        cfg_ovr = 150;
        bridge_count = 16'hf52f;
        pass(32'h3, 0);
        bridge_count = 16'hffff;
        pass(32'h1, 0);
        bridge_count = 16'h0000;
        pass(32'h1, 0);
        latency = 8'h02;
        bridge_count = 16'h8a66;
        nul = f_v(bridge_count);
        // let a bridge sample of the old scene drain before the capture is armed
        wait_refs(1);
        pass(32'h5, 1);
        bridge_count = 16'h8e4e;
        pass(32'h1, 1);
        nul = 0;
        pass(32'h9, 0);
        cfg_sw = 512;
        pass(32'h1, 0);
        test_done;
    end

    initial
    begin
        #2000000;
        failures++;
        test_done;
    end
endmodule // tb_brl_readout

`default_nettype wire
